//--- bench/dpcpwm_fet_model.sv
// Behavioural power switch with a current-sense comparator per channel.
`timescale 1ns/1ps
module dpcpwm_fet_model (
   // Clock
   input  wire logic       sys_clk_i,
   // Gate drives and test controls
   input  wire logic [1:0] gate_i,
   input  wire logic [1:0] trip_en_i,
   input  wire logic [3:0] ramp_len_i,
   // Comparator outputs
   output logic      [1:0] trip_o
);
   logic [3:0] ramp_ff [2];
   // Inductor current ramps only while the switch is on and resets when off.
   always_ff @(posedge sys_clk_i) begin
      for (int i = 0; i < 2; i++) begin
         if (!gate_i[i]) ramp_ff[i] <= 4'h0;
         else if (ramp_ff[i] != 4'hF) ramp_ff[i] <= ramp_ff[i] + 4'h1;
      end
   end
   // The comparator trips once the ramp reaches the level; no current, no trip.
   always_comb begin
      for (int i = 0; i < 2; i++) trip_o[i] = trip_en_i[i] && gate_i[i] && ramp_ff[i] >= ramp_len_i;
   end
endmodule : dpcpwm_fet_model

//--- bench/dpcpwm_monitor.sv
// Port checker for the dual peak-current PWM block.
`timescale 1ns/1ps
module dpcpwm_monitor (
   // Clock, reset and enable
   input wire logic                        sys_clk_i,
   input wire logic                        sys_rst_i,
   input wire logic                        ce_i,
   // Register bus
   input wire logic                        psel_i,
   input wire logic                        penable_i,
   input wire logic                        pwrite_i,
   input wire logic [7:0]                  paddr_i,
   input wire logic [31:0]                 pwdata_i,
   input wire logic                        pslverr_o,
   // Analog status and drives
   input wire logic [1:0]                  current_trip_input_i,
   input wire logic                        overtemp_i,
   input wire logic                        gate_drive_a_o,
   input wire logic                        gate_drive_b_o,
   input wire dpcpwm_pkg::dpcpwm_ana_type [1:0] ana_o,
   input wire logic [7:0]                  sense_offset_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic        wr;
   logic [15:0] since_a_ff;
   logic        ga_q_ff;
   logic        seen_a_ff;
   logic [3:0]  trip_cnt_ff;
   assign wr = psel_i && penable_i && pwrite_i && ce_i;
   // Clocks since the master gate rose; saturates so the grid test stays honest.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         since_a_ff <= 16'h0;
         ga_q_ff    <= 1'b0;
         seen_a_ff  <= 1'b0;
      end else begin
         ga_q_ff <= gate_drive_a_o;
         if (gate_drive_a_o && !ga_q_ff) begin
            since_a_ff <= 16'h1;
            seen_a_ff  <= 1'b1;
         end else if (since_a_ff != 16'hFFFF) begin
            since_a_ff <= since_a_ff + 16'h1;
         end
      end
   end
   // Length of on-time spent with the trip already high.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         trip_cnt_ff <= 4'h0;
      end else if (gate_drive_a_o && current_trip_input_i[0]) begin
         trip_cnt_ff <= (trip_cnt_ff == 4'hF) ? 4'hF : trip_cnt_ff + 4'h1;
      end else begin
         trip_cnt_ff <= 4'h0;
      end
   end
   AST_OT_OFF: assert property (overtemp_i [*7] |-> !gate_drive_a_o && !gate_drive_b_o)
      else $error("gate on during overtemperature");
   AST_TRIP_END: assert property (trip_cnt_ff <= 4'hD)
      else $error("gate stayed on after trip");
   AST_TICK_GRID: assert property ($rose(gate_drive_a_o) && seen_a_ff && ~&since_a_ff
      |-> since_a_ff % 5 == 0) else $error("master period off tick grid");
   AST_PHASE_GRID: assert property ($rose(gate_drive_b_o) && seen_a_ff && ~&since_a_ff
      |-> since_a_ff % 5 == 0) else $error("slave start off tick grid");
   AST_COMP_RST: assert property ($fell(sys_rst_i) |-> ana_o[0].volt_comp_reset &&
      ana_o[0].curr_comp_reset && ana_o[1].volt_comp_reset && ana_o[1].curr_comp_reset
      && !gate_drive_a_o && !gate_drive_b_o) else $error("reset state wrong");
   AST_VREF_WR: assert property ($changed(ana_o[0].volt_ref) |->
      $past(wr && paddr_i == dpcpwm_pkg::ADDR_VREF_A) && ana_o[0].volt_ref == $past(pwdata_i[7:0]))
      else $error("volt ref changed without write");
   AST_SLOPE_WR: assert property ($changed(ana_o[1].slope) |->
      $past(wr && paddr_i == dpcpwm_pkg::ADDR_SLOPE) && ana_o[1].slope == $past(pwdata_i[13:8]))
      else $error("slope changed without write");
   AST_OFFS_WR: assert property ($changed(sense_offset_o) |->
      $past(wr && paddr_i == dpcpwm_pkg::ADDR_OFFS) && sense_offset_o == $past(pwdata_i[7:0]))
      else $error("offset changed without write");
   AST_ERR_ACC: assert property (pslverr_o == (psel_i && penable_i &&
      (paddr_i[1:0] != 2'h0 || paddr_i > dpcpwm_pkg::ADDR_IRQ_MK)))
      else $error("slave error wrong");
   COV_SLAVE: cover property ($rose(gate_drive_b_o));
   COV_TRIP: cover property (trip_cnt_ff == 4'h3);
   COV_ERR: cover property (pslverr_o);
   COV_OT: cover property (overtemp_i [*7]);
endmodule : dpcpwm_monitor

bind dpcpwm_top dpcpwm_monitor u_dpcpwm_monitor (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
   .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .pslverr_o(pslverr_o), .current_trip_input_i(current_trip_input_i),
   .overtemp_i(overtemp_i), .gate_drive_a_o(gate_drive_a_o), .gate_drive_b_o(gate_drive_b_o),
   .ana_o(ana_o), .sense_offset_o(sense_offset_o));

//--- bench/tb.sv
// Self-checking bench for the dual peak-current PWM block.
`timescale 1ns/1ps
module tb;
   logic        sys_clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        psel_i = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i = 1'b0;
   logic [7:0]  paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic [1:0]  loop_act = 2'h0;
   logic [1:0]  loop_dom = 2'h0;
   logic [1:0]  trip_en = 2'h0;
   logic        overtemp = 1'b0;
   logic [31:0] prdata_o, rd;
   logic        pready_o, pslverr_o, err, irq;
   logic [1:0]  trip, g, g_q;
   logic [7:0]  offs;
   dpcpwm_pkg::dpcpwm_ana_type [1:0] ana;
   int          miscompares = 0, samples_checked = 0, cyc = 0, t, cnt;
   int          rise_c[2], prv_c[2], hi_c[2], hi_blk[4];
   dpcpwm_top u_dpcpwm_top (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .current_trip_input_i(trip), .loop_active_status_i(loop_act),
      .dominant_loop_select_i(loop_dom), .overtemp_i(overtemp), .gate_drive_a_o(g[0]),
      .gate_drive_b_o(g[1]), .ana_o(ana), .sense_offset_o(offs), .irq_o(irq));
   dpcpwm_fet_model u_dpcpwm_fet_model (.sys_clk_i(sys_clk_i), .gate_i(g), .trip_en_i(trip_en),
      .ramp_len_i(4'h2), .trip_o(trip));
   // Clock at 40 MHz.
   always #12.5 sys_clk_i = ~sys_clk_i;
   // Gate edges are logged on the falling edge, clear of the launch edge.
   always @(negedge sys_clk_i) begin
      cyc++;
      for (int i = 0; i < 2; i++) begin
         if (g[i] && !g_q[i]) begin
            prv_c[i] = rise_c[i];
            rise_c[i] = cyc;
         end
         if (!g[i] && g_q[i]) hi_c[i] = cyc - rise_c[i];
      end
      g_q = g;
      if (cyc == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   // One APB transfer, bounded wait.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      rd = prdata_o;
      err = pslverr_o;
      {psel_i, penable_i} <= 2'b00;
      if (n >= 50) miscompares++;
   endtask : apb
   // Write, then let the stored value reach the outputs.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      @(negedge sys_clk_i);
   endtask : wr
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc
   task automatic give_verdict;
      if (miscompares == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : give_verdict
   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      repeat (20) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(negedge sys_clk_i);
      chk({ana[0].volt_comp_reset, ana[1].curr_comp_reset, g}, 4'hC);
      rdc(dpcpwm_pkg::ADDR_PERIOD, 32'hFF);
      rdc(dpcpwm_pkg::ADDR_DUTY, 32'h80);
      rdc(dpcpwm_pkg::ADDR_LOOP_A, 32'h3);
      rdc(dpcpwm_pkg::ADDR_IRQ_ST, 32'h0);
      rdc(8'h38, 32'h0);
      chk(err, 1'b1);
      wr(8'h01, 32'hFF);
      chk(err, 1'b1);
      for (int c = 0; c < 256; c += 51) begin
         wr(dpcpwm_pkg::ADDR_VREF_A, 32'(c));
         chk(ana[0].volt_ref, 32'(c));
      end
      wr(dpcpwm_pkg::ADDR_CREF_B, 32'h1A5);
      chk(ana[1].curr_ref, 8'hA5);
      wr(dpcpwm_pkg::ADDR_SLOPE, 32'hFFFF);
      rdc(dpcpwm_pkg::ADDR_SLOPE, 32'h3F3F);
      wr(dpcpwm_pkg::ADDR_OFFS, 32'h5A);
      chk(offs, 8'h5A);
      wr(dpcpwm_pkg::ADDR_PERIOD, 32'd9);
      wr(dpcpwm_pkg::ADDR_DUTY, 32'd4);
      wr(dpcpwm_pkg::ADDR_PHASE, 32'd3);
      wr(dpcpwm_pkg::ADDR_LOOP_A, 32'h4);
      wr(dpcpwm_pkg::ADDR_LOOP_B, 32'h4);
      chk({ana[1].volt_comp_reset, ana[1].curr_comp_reset, ana[0].curr_comp_reset}, 0);
      repeat (200) @(posedge sys_clk_i);
      chk(rise_c[0] - prv_c[0], 50);
      chk(rise_c[1] - prv_c[1], 50);
      chk(hi_c[0], 20);
      chk((rise_c[1] - rise_c[0] + 500) % 50, 15);
      wr(dpcpwm_pkg::ADDR_PHASE, 32'd60);
      repeat (200) @(posedge sys_clk_i);
      chk((rise_c[1] - rise_c[0] + 500) % 50, 0);
      trip_en <= 2'b01;
      for (int b = 0; b < 4; b++) begin
         wr(dpcpwm_pkg::ADDR_BLANK, 32'(b));
         repeat (200) @(posedge sys_clk_i);
         hi_blk[b] = hi_c[0];
         chk(hi_blk[b] < 20, 1);
         chk(rise_c[0] - prv_c[0], 50);
      end
      chk(hi_blk[3] > hi_blk[0] && hi_blk[3] >= 8, 1);
      @(posedge sys_clk_i);
      trip_en <= 2'b00;
      wr(dpcpwm_pkg::ADDR_IRQ_MK, 32'h1);
      @(posedge sys_clk_i);
      overtemp <= 1'b1;
      repeat (10) @(posedge sys_clk_i);
      cnt = 0;
      repeat (100) @(negedge sys_clk_i) cnt += g[0] | g[1];
      chk(cnt, 0);
      chk(irq, 1'b1);
      rdc(dpcpwm_pkg::ADDR_IRQ_ST, 32'h1);
      @(posedge sys_clk_i);
      overtemp <= 1'b0;
      repeat (10) @(posedge sys_clk_i);
      wr(dpcpwm_pkg::ADDR_IRQ_ST, 32'h1);
      chk(irq, 1'b0);
      t = cyc;
      repeat (150) @(posedge sys_clk_i);
      chk(rise_c[0] > t && rise_c[1] > t, 1);
      wr(dpcpwm_pkg::ADDR_IRQ_MK, 32'h0);
      @(posedge sys_clk_i);
      {loop_act, loop_dom} <= 4'h5;
      repeat (10) @(posedge sys_clk_i);
      rdc(dpcpwm_pkg::ADDR_IRQ_ST, 32'h2);
      chk(irq, 1'b0);
      rdc(dpcpwm_pkg::ADDR_LOOP_A, 32'h34);
      rdc(dpcpwm_pkg::ADDR_LOOP_B, 32'h04);
      wr(dpcpwm_pkg::ADDR_IRQ_MK, 32'h6);
      chk(irq, 1'b1);
      wr(dpcpwm_pkg::ADDR_IRQ_ST, 32'h2);
      chk(irq, 1'b0);
      @(posedge sys_clk_i);
      loop_act <= 2'b11;
      repeat (10) @(posedge sys_clk_i);
      rdc(dpcpwm_pkg::ADDR_IRQ_ST, 32'h4);
      give_verdict();
   end
endmodule : tb

//--- src/dpcpwm_pkg.sv
// Constants, register map and carrier types for the dual peak-current PWM block.
package dpcpwm_pkg;

   // ---------------------------------------------------------------
   // Clocking and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ   = 40_000_000;
   localparam int unsigned OSC_HZ   = 8_000_000;
   localparam int unsigned CLK_MHZ  = CLK_HZ / 1_000_000;
   localparam int unsigned TICK_DIV = CLK_HZ / OSC_HZ;
   localparam logic [2:0]  TICK_LAST = 3'(TICK_DIV - 1);

   // Blanking times in ns, rounded up to whole system clock cycles.
   localparam int unsigned LEB_NS_1 = 50;
   localparam int unsigned LEB_NS_2 = 100;
   localparam int unsigned LEB_NS_3 = 200;
   localparam logic [3:0]  LEB_CYC_0 = 4'h0;
   localparam logic [3:0]  LEB_CYC_1 = 4'((LEB_NS_1 * CLK_MHZ + 999) / 1000);
   localparam logic [3:0]  LEB_CYC_2 = 4'((LEB_NS_2 * CLK_MHZ + 999) / 1000);
   localparam logic [3:0]  LEB_CYC_3 = 4'((LEB_NS_3 * CLK_MHZ + 999) / 1000);

   // Period divider range; the register holds N minus one.
   localparam int unsigned N_MIN   = 4;
   localparam int unsigned N_MAX   = 256;
   localparam logic [7:0]  PER_MIN = 8'(N_MIN - 1);

   // Reference DAC steps in microvolts per code.
   localparam int unsigned VREF_STEP_UV = 8000;
   localparam int unsigned CREF_STEP_UV = 4000;

   // ---------------------------------------------------------------
   // Register map (byte addresses) and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_PERIOD = 8'h00;
   localparam logic [7:0] ADDR_DUTY   = 8'h04;
   localparam logic [7:0] ADDR_BLANK  = 8'h08;
   localparam logic [7:0] ADDR_OFFS   = 8'h0C;
   localparam logic [7:0] ADDR_SLOPE  = 8'h10;
   localparam logic [7:0] ADDR_PHASE  = 8'h14;
   localparam logic [7:0] ADDR_VREF_A = 8'h18;
   localparam logic [7:0] ADDR_VREF_B = 8'h1C;
   localparam logic [7:0] ADDR_CREF_A = 8'h20;
   localparam logic [7:0] ADDR_CREF_B = 8'h24;
   localparam logic [7:0] ADDR_LOOP_A = 8'h28;
   localparam logic [7:0] ADDR_LOOP_B = 8'h2C;
   localparam logic [7:0] ADDR_IRQ_ST = 8'h30;
   localparam logic [7:0] ADDR_IRQ_MK = 8'h34;

   localparam logic [7:0] RST_PERIOD = 8'hFF;
   localparam logic [7:0] RST_DUTY   = 8'h80;
   localparam logic [7:0] RST_CODE   = 8'h00;
   localparam logic [5:0] RST_SLOPE  = 6'h00;
   localparam logic [2:0] RST_LOOP   = 3'h3;

   // Field positions.
   localparam int unsigned LC_VRST  = 0;
   localparam int unsigned LC_CRST  = 1;
   localparam int unsigned LC_DRVEN = 2;
   localparam int unsigned LC_ACT   = 4;
   localparam int unsigned LC_DOM   = 5;
   localparam int unsigned SLOPE_B  = 8;
   localparam int unsigned IRQ_OT   = 0;
   localparam int unsigned IRQ_LOOP = 1;

   // Analog-side settings of one channel.
   typedef struct packed {
      logic [7:0] volt_ref;
      logic [7:0] curr_ref;
      logic [5:0] slope;
      logic       volt_comp_reset;
      logic       curr_comp_reset;
   } dpcpwm_ana_type;

endpackage : dpcpwm_pkg

//--- src/dpcpwm_top.sv
// Dual peak-current PWM control with APB registers and interrupt.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps

// Overview of operation
// - Selectable 0/50/100/200 ns trip blanking
// - Current trip latches driver off until next cycle
// - Frequency is 8 MHz over N, 4..256
// - Shared frequency, slave has phase offset
// - On-time limited by duty-limit register
// - Four 8-bit reference codes from firmware
// - Voltage code step is 8 mV
// - Current code step is 4 mV
// - Software compensation reset bits per channel
// - Loop-active status, interrupt, dominant loop bit
// - Overtemperature disables drivers, sets flag
// - Switching resumes when overtemperature clears
// - Programmable sense offset code, current limit
// - 6-bit slope compensation code
module dpcpwm_top (
   // Clock, reset and enable
   input  wire logic                             sys_clk_i,
   input  wire logic                             sys_rst_i,
   input  wire logic                             ce_i,
   // APB slave
   input  wire logic                             psel_i,
   input  wire logic                             penable_i,
   input  wire logic                             pwrite_i,
   input  wire logic [7:0]                       paddr_i,
   input  wire logic [31:0]                      pwdata_i,
   output logic      [31:0]                      prdata_o,
   output logic                                  pready_o,
   output logic                                  pslverr_o,
   // Analog status pins, asynchronous
   input  wire logic [1:0]                       current_trip_input_i,
   input  wire logic [1:0]                       loop_active_status_i,
   input  wire logic [1:0]                       dominant_loop_select_i,
   input  wire logic                             overtemp_i,
   // Gate drives, analog settings and interrupt
   output logic                                  gate_drive_a_o,
   output logic                                  gate_drive_b_o,
   output dpcpwm_pkg::dpcpwm_ana_type [1:0]      ana_o,
   output logic      [7:0]                       sense_offset_o,
   output logic                                  irq_o
);

   // ---------------------------------------------------------------
   // Registers and internal signals
   // ---------------------------------------------------------------
   logic [7:0]  period_ff;
   logic [7:0]  duty_ff;
   logic [3:0]  blank_sel_ff;
   logic [7:0]  offset_ff;
   logic [5:0]  slope_ff [1:0];
   logic [7:0]  phase_ff;
   logic [7:0]  vref_ff [1:0];
   logic [7:0]  cref_ff [1:0];
   logic [2:0]  loop_ff [1:0];
   logic [2:0]  irq_st_ff;
   logic [2:0]  irq_mk_ff;
   logic [31:0] prdata_ff;

   logic [6:0]  raw;
   logic [6:0]  s1_ff;
   logic [6:0]  s2_ff;
   logic [6:0]  s3_ff;
   logic [6:0]  flt_ff;
   logic [6:0]  agree;
   logic [1:0]  trip_f;
   logic [1:0]  act_f;
   logic [1:0]  dom_f;
   logic        ot_f;
   logic [1:0]  act_d_ff;

   logic [2:0]  tick_cnt_ff;
   logic        tick;
   logic [7:0]  cnt_ff;
   logic [7:0]  per_eff;
   logic [7:0]  ph_eff;
   logic [7:0]  lcnt [1:0];
   logic [1:0]  on_ff;

   logic        wr_en;
   logic        rd_setup;
   logic        hit;
   logic [31:0] nxt_prdata;
   logic [2:0]  nxt_irq_st;

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   assign raw = {overtemp_i, dominant_loop_select_i, loop_active_status_i,
                 current_trip_input_i};

   // Three stages; the filtered copy follows only when stages two and three agree.
   assign agree = ~(s2_ff ^ s3_ff);

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s1_ff  <= 7'h00;
         s2_ff  <= 7'h00;
         s3_ff  <= 7'h00;
         flt_ff <= 7'h00;
      end else if (ce_i) begin
         s1_ff  <= raw;
         s2_ff  <= s1_ff;
         s3_ff  <= s2_ff;
         flt_ff <= (agree & s3_ff) | (~agree & flt_ff);
      end
   end

   assign trip_f = flt_ff[1:0];
   assign act_f  = flt_ff[3:2];
   assign dom_f  = flt_ff[5:4];
   assign ot_f   = flt_ff[6];

   // ---------------------------------------------------------------
   // Switching time base
   // ---------------------------------------------------------------
   // Divide the system clock down to the 8 MHz oscillator rate.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tick_cnt_ff <= 3'h0;
      end else if (ce_i) begin
         tick_cnt_ff <= (tick_cnt_ff == dpcpwm_pkg::TICK_LAST) ? 3'h0 : tick_cnt_ff + 3'h1;
      end
   end

   assign tick = ce_i && (tick_cnt_ff == dpcpwm_pkg::TICK_LAST);

   // Values below the minimum divider are raised to it, so N never drops under 4.
   // period divider clamp
   assign per_eff = (period_ff < dpcpwm_pkg::PER_MIN) ? dpcpwm_pkg::PER_MIN : period_ff;

   // Master period counter, shared by both channels.
   // common frequency
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_ff <= 8'h00;
      end else if (tick) begin
         cnt_ff <= (cnt_ff >= per_eff) ? 8'h00 : cnt_ff + 8'h01;
      end
   end

   // A phase beyond the period reads as no shift, so the slave never loses its start.
   // wrapped slave phase
   assign ph_eff  = (phase_ff > per_eff) ? 8'h00 : phase_ff;
   assign lcnt[0] = cnt_ff;
   assign lcnt[1] = (cnt_ff >= ph_eff) ? cnt_ff - ph_eff
                  : 8'(9'(cnt_ff) + 9'(per_eff) + 9'h001 - 9'(ph_eff));

   // ---------------------------------------------------------------
   // Per-channel PWM
   // ---------------------------------------------------------------
   for (genvar i = 0; i < 2; i++) begin : g_ch
      logic [7:0] on_cnt_ff;
      logic [3:0] blank_ff;
      logic [3:0] leb_cyc;
      logic       start;
      logic       run_ok;

      // A cycle starts at the tick that wraps the channel's own count to zero.
      assign start  = tick && (lcnt[i] >= per_eff);
      assign run_ok = loop_ff[i][dpcpwm_pkg::LC_DRVEN] && !ot_f;

      always_comb begin
         unique case (blank_sel_ff[2*i +: 2])
            2'h0: leb_cyc = dpcpwm_pkg::LEB_CYC_0;
            2'h1: leb_cyc = dpcpwm_pkg::LEB_CYC_1;
            2'h2: leb_cyc = dpcpwm_pkg::LEB_CYC_2;
            2'h3: leb_cyc = dpcpwm_pkg::LEB_CYC_3;
         endcase
      end

      // Blanking counter runs on the system clock for finer steps than the tick.
      // blanking window
      always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            blank_ff <= 4'h0;
         end else if (ce_i) begin
            if (start) begin
               blank_ff <= leb_cyc;
            end else if (blank_ff != 4'h0) begin
               blank_ff <= blank_ff - 4'h1;
            end
         end
      end

      // Set-reset latch: set at cycle start, cleared by trip, duty limit or shutdown.
      always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            on_ff[i]  <= 1'b0;
            on_cnt_ff <= 8'h00;
         end else if (ce_i) begin
            if (!run_ok) begin
               on_ff[i] <= 1'b0;
            end else if (start) begin
               on_ff[i]  <= (duty_ff != 8'h00);
               on_cnt_ff <= 8'h00;
            end else if (on_ff[i] && trip_f[i] && (blank_ff == 4'h0)) begin
               on_ff[i] <= 1'b0;
            end else if (tick && on_ff[i]) begin
               on_cnt_ff <= on_cnt_ff + 8'h01;
               if (9'(on_cnt_ff) + 9'h001 >= 9'(duty_ff)) begin
                  on_ff[i] <= 1'b0;
               end
            end
         end
      end

      // Analog settings straight from the register file.
      // reference codes out
      assign ana_o[i].volt_ref        = vref_ff[i];
      assign ana_o[i].curr_ref        = cref_ff[i];
      assign ana_o[i].slope           = slope_ff[i];
      assign ana_o[i].volt_comp_reset = loop_ff[i][dpcpwm_pkg::LC_VRST];
      assign ana_o[i].curr_comp_reset = loop_ff[i][dpcpwm_pkg::LC_CRST];
   end

   assign gate_drive_a_o = on_ff[0];
   assign gate_drive_b_o = on_ff[1];

   assign sense_offset_o = offset_ff;

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   // Zero-wait slave; read data is captured in the setup cycle.
   assign wr_en    = psel_i && penable_i && pwrite_i;
   assign rd_setup = psel_i && !penable_i && !pwrite_i;
   assign pready_o = 1'b1;

   // Read mux and address decode.
   always_comb begin
      nxt_prdata = 32'h0000_0000;
      hit        = 1'b1;
      unique case (paddr_i)
         dpcpwm_pkg::ADDR_PERIOD: nxt_prdata[7:0] = period_ff;
         dpcpwm_pkg::ADDR_DUTY:   nxt_prdata[7:0] = duty_ff;
         dpcpwm_pkg::ADDR_BLANK:  nxt_prdata[3:0] = blank_sel_ff;
         dpcpwm_pkg::ADDR_OFFS:   nxt_prdata[7:0] = offset_ff;
         dpcpwm_pkg::ADDR_SLOPE:  nxt_prdata[13:0] = {slope_ff[1], 2'h0, slope_ff[0]};
         dpcpwm_pkg::ADDR_PHASE:  nxt_prdata[7:0] = phase_ff;
         dpcpwm_pkg::ADDR_VREF_A: nxt_prdata[7:0] = vref_ff[0];
         dpcpwm_pkg::ADDR_VREF_B: nxt_prdata[7:0] = vref_ff[1];
         dpcpwm_pkg::ADDR_CREF_A: nxt_prdata[7:0] = cref_ff[0];
         dpcpwm_pkg::ADDR_CREF_B: nxt_prdata[7:0] = cref_ff[1];
         dpcpwm_pkg::ADDR_LOOP_A: nxt_prdata[5:0] = {dom_f[0], act_f[0], 1'b0, loop_ff[0]};
         dpcpwm_pkg::ADDR_LOOP_B: nxt_prdata[5:0] = {dom_f[1], act_f[1], 1'b0, loop_ff[1]};
         dpcpwm_pkg::ADDR_IRQ_ST: nxt_prdata[2:0] = irq_st_ff;
         dpcpwm_pkg::ADDR_IRQ_MK: nxt_prdata[2:0] = irq_mk_ff;
         default:                 hit = 1'b0;
      endcase
   end

   assign pslverr_o = psel_i && penable_i && !hit;

   // Read data register.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prdata_ff <= 32'h0000_0000;
      end else if (ce_i && rd_setup) begin
         prdata_ff <= nxt_prdata;
      end
   end

   assign prdata_o = prdata_ff;

   // Timing configuration registers.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         period_ff    <= dpcpwm_pkg::RST_PERIOD;
         duty_ff      <= dpcpwm_pkg::RST_DUTY;
         blank_sel_ff <= 4'h0;
         phase_ff     <= 8'h00;
      end else if (ce_i && wr_en) begin
         if (paddr_i == dpcpwm_pkg::ADDR_PERIOD) period_ff    <= pwdata_i[7:0];
         if (paddr_i == dpcpwm_pkg::ADDR_DUTY)   duty_ff      <= pwdata_i[7:0];
         if (paddr_i == dpcpwm_pkg::ADDR_BLANK)  blank_sel_ff <= pwdata_i[3:0];
         if (paddr_i == dpcpwm_pkg::ADDR_PHASE)  phase_ff     <= pwdata_i[7:0];
      end
   end

   // Analog code registers; firmware ramps the references for soft start.
   // firmware ramped references
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         offset_ff   <= dpcpwm_pkg::RST_CODE;
         slope_ff[0] <= dpcpwm_pkg::RST_SLOPE;
         slope_ff[1] <= dpcpwm_pkg::RST_SLOPE;
         vref_ff[0]  <= dpcpwm_pkg::RST_CODE;
         vref_ff[1]  <= dpcpwm_pkg::RST_CODE;
         cref_ff[0]  <= dpcpwm_pkg::RST_CODE;
         cref_ff[1]  <= dpcpwm_pkg::RST_CODE;
      end else if (ce_i && wr_en) begin
         if (paddr_i == dpcpwm_pkg::ADDR_OFFS) offset_ff <= pwdata_i[7:0];
         if (paddr_i == dpcpwm_pkg::ADDR_SLOPE) begin
            slope_ff[0] <= pwdata_i[5:0];
            slope_ff[1] <= pwdata_i[dpcpwm_pkg::SLOPE_B +: 6];
         end
         if (paddr_i == dpcpwm_pkg::ADDR_VREF_A) vref_ff[0] <= pwdata_i[7:0];
         if (paddr_i == dpcpwm_pkg::ADDR_VREF_B) vref_ff[1] <= pwdata_i[7:0];
         if (paddr_i == dpcpwm_pkg::ADDR_CREF_A) cref_ff[0] <= pwdata_i[7:0];
         if (paddr_i == dpcpwm_pkg::ADDR_CREF_B) cref_ff[1] <= pwdata_i[7:0];
      end
   end

   // Loop control; resets start asserted so the networks are discharged until released.
   // reset bit storage
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         loop_ff[0] <= dpcpwm_pkg::RST_LOOP;
         loop_ff[1] <= dpcpwm_pkg::RST_LOOP;
      end else if (ce_i && wr_en) begin
         if (paddr_i == dpcpwm_pkg::ADDR_LOOP_A) loop_ff[0] <= pwdata_i[2:0];
         if (paddr_i == dpcpwm_pkg::ADDR_LOOP_B) loop_ff[1] <= pwdata_i[2:0];
      end
   end

   // ---------------------------------------------------------------
   // Interrupts
   // ---------------------------------------------------------------
   // Write-one-to-clear; a set in the same cycle wins over the clear.
   always_comb begin
      nxt_irq_st = irq_st_ff;
      if (wr_en && (paddr_i == dpcpwm_pkg::ADDR_IRQ_ST)) begin
         nxt_irq_st = irq_st_ff & ~pwdata_i[2:0];
      end
      if (ot_f) begin
         nxt_irq_st[dpcpwm_pkg::IRQ_OT] = 1'b1;
      end
      if (act_f[0] && !act_d_ff[0]) begin
         nxt_irq_st[dpcpwm_pkg::IRQ_LOOP] = 1'b1;
      end
      if (act_f[1] && !act_d_ff[1]) begin
         nxt_irq_st[dpcpwm_pkg::IRQ_LOOP + 1] = 1'b1;
      end
   end

   // Status flags and loop-active edge history.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_st_ff <= 3'h0;
         act_d_ff  <= 2'h0;
      end else if (ce_i) begin
         irq_st_ff <= nxt_irq_st;
         act_d_ff  <= act_f;
      end
   end

   // Mask register.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_mk_ff <= 3'h0;
      end else if (ce_i && wr_en && (paddr_i == dpcpwm_pkg::ADDR_IRQ_MK)) begin
         irq_mk_ff <= pwdata_i[2:0];
      end
   end

   assign irq_o = |(irq_st_ff & irq_mk_ff);

endmodule : dpcpwm_top
